// ---- core/rcs_regs.vh ----
// constants for the reset configuration strap sampler
// assumes a 10 mhz platform clock and an active-low hard reset pin
// Notes on behaviour
// - during hard reset every configuration pin is treated as an input
// - on hard reset release, latch each pin, drop its receiver, restore output role
// - gated pull-up on only during hard reset plus a few clocks, off with receiver
// - high level on each sampled bit selects the default setting
// - tap controller also resets through tck and tms alone, without test reset
// - soft reset assertion raises a machine check interrupt to the core
`ifndef RCS_REGS_VH
`define RCS_REGS_VH
`define RCS_CFG_WIDTH 16
`define RCS_RATIO_WIDTH 4
`define RCS_HOLD_CLKS 4
`define RCS_TMS_RESET_ONES 5
`define RCS_TAP_RESET 4'h0
`define RCS_TAP_IDLE 4'h1
`define RCS_TAP_SEL_DR 4'h2
`define RCS_TAP_CAP_DR 4'h3
`define RCS_TAP_SHIFT_DR 4'h4
`define RCS_TAP_EXIT1_DR 4'h5
`define RCS_TAP_PAUSE_DR 4'h6
`define RCS_TAP_EXIT2_DR 4'h7
`define RCS_TAP_UPD_DR 4'h8
`define RCS_TAP_SEL_IR 4'h9
`define RCS_TAP_CAP_IR 4'ha
`define RCS_TAP_SHIFT_IR 4'hb
`define RCS_TAP_EXIT1_IR 4'hc
`define RCS_TAP_PAUSE_IR 4'hd
`define RCS_TAP_EXIT2_IR 4'he
`define RCS_TAP_UPD_IR 4'hf
`endif

// ---- core/rcs_strap_sampler.v ----
// top of the reset configuration strap sampler
// holds the strap capture window, pad gating, machine check and tap reset tracking
// assumes clk runs free during hard reset; nrst is the on-chip power-on reset
// assumes strap pads are ordinary output pads with a receiver; config pads also have a gated pull-up
// assumes tck runs at a quarter of clk or slower
// assumes func_out and ratio_func_out come from logic on clk
`include "rcs_regs.vh"
module rcs_strap_sampler #(
  parameter CFG_W = `RCS_CFG_WIDTH,
  parameter RATIO_W = `RCS_RATIO_WIDTH,
  parameter HOLD_CLKS = `RCS_HOLD_CLKS
) (
  input wire clk,
  input wire nrst,
  input wire hard_reset_n,
  input wire soft_reset_n,
  input wire trst_n,
  input wire tck,
  input wire tms,
  input wire [CFG_W-1:0] cfg_pin_i,
  input wire [RATIO_W-1:0] ratio_pin_i,
  input wire [CFG_W-1:0] func_out,
  input wire [RATIO_W-1:0] ratio_func_out,
  output wire [CFG_W-1:0] cfg_pin_o,
  output wire [CFG_W-1:0] cfg_pin_oe,
  output wire [RATIO_W-1:0] ratio_pin_o,
  output wire [RATIO_W-1:0] ratio_pin_oe,
  output reg [CFG_W-1:0] cfg_pullup_en_q,
  output reg [CFG_W-1:0] cfg_rx_en_q,
  output reg [RATIO_W-1:0] ratio_rx_en_q,
  output reg [CFG_W-1:0] cfg_value_q,
  output reg [RATIO_W-1:0] ratio_value_q,
  output reg cfg_valid_q,
  output reg machine_check_q,
  output wire [3:0] tap_state,
  output wire tap_in_reset
);
  // phases of the strap window
  localparam PH_RESET = 2'h0;
  localparam PH_HOLD = 2'h1;
  localparam PH_RUN = 2'h2;

  // hold count reload, one below HOLD_CLKS; the pull-up window lasts HOLD_CLKS clocks after capture
  localparam [7:0] HOLD_RELOAD = HOLD_CLKS[7:0] - 8'h1;

  // true while the pads must stay in listening mode, receivers and pull-ups on
  function pads_listen;
    input [1:0] phase;
    begin
      pads_listen = (phase != PH_RUN);
    end
  endfunction

  // pin synchronisers: stage 0 is never read by logic, stage 1 is the clean copy
  reg [2:0] hr_meta_q;
  reg [1:0] sr_meta_q;
  reg [1:0] trst_meta_q;
  reg [2:0] tck_meta_q;
  reg [1:0] tms_meta_q;
  reg [CFG_W-1:0] cfg_s1_q;
  reg [CFG_W-1:0] cfg_s2_q;
  reg [RATIO_W-1:0] ratio_s1_q;
  reg [RATIO_W-1:0] ratio_s2_q;

  // strap window sequencer
  reg [1:0] phase_q;
  reg [1:0] phase_d;
  reg [7:0] hold_cnt_q;

  // clean pin levels and derived strobes
  wire hr_n_sync;
  wire hr_n_prev;
  wire sr_n_sync;
  wire trst_n_sync;
  wire tms_sync;
  wire tck_rise;
  wire capture_now;
  wire listen_d;
  wire hold_done;

  // taps off the synchroniser chains
  assign hr_n_sync = hr_meta_q[1];
  assign hr_n_prev = hr_meta_q[2];
  assign sr_n_sync = sr_meta_q[1];
  assign trst_n_sync = trst_meta_q[1];
  assign tms_sync = tms_meta_q[1];
  assign tck_rise = tck_meta_q[1] & ~tck_meta_q[2];

  // capture strobe: first clock that sees hard reset released after the sync
  assign capture_now = hr_n_sync & ~hr_n_prev;
  // hold count spent: pull-up has covered its settling window
  assign hold_done = (hold_cnt_q == 8'h0);
  // next-cycle pad mode; registered so pads never glitch on a phase change
  assign listen_d = pads_listen(phase_d);

  // hard and soft reset pins: two flops each, third hard reset stage for the edge
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hr_meta_q <= 3'h0; // seen as asserted, so no false capture at power-up
      sr_meta_q <= 2'h3;
    end else begin
      hr_meta_q <= {hr_meta_q[1:0], hard_reset_n};
      sr_meta_q <= {sr_meta_q[0], soft_reset_n};
    end
  end

  // test pins: tck must run well below clk or rising edges are lost
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trst_meta_q <= 2'h0;
      tck_meta_q <= 3'h0; // matches tck idle low, no false edge after reset
      tms_meta_q <= 2'h3;
    end else begin
      trst_meta_q <= {trst_meta_q[0], trst_n};
      tck_meta_q <= {tck_meta_q[1:0], tck};
      tms_meta_q <= {tms_meta_q[0], tms};
    end
  end

  // strap pads sampled as whole words; safe only because they hold still in reset
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_s1_q <= {CFG_W{1'b1}};
      cfg_s2_q <= {CFG_W{1'b1}};
      ratio_s1_q <= {RATIO_W{1'b0}};
      ratio_s2_q <= {RATIO_W{1'b0}};
    end else begin
      cfg_s1_q <= cfg_pin_i;
      cfg_s2_q <= cfg_s1_q;
      ratio_s1_q <= ratio_pin_i;
      ratio_s2_q <= ratio_s1_q;
    end
  end

  // window sequencer: reset, pull-up hold after release, then run
  // a hard reset during the hold phase restarts the window from the top
  always @* begin
    phase_d = phase_q;
    case (phase_q)
      PH_RESET: phase_d = hr_n_sync ? PH_HOLD : PH_RESET;
      PH_HOLD: phase_d = !hr_n_sync ? PH_RESET : (hold_done ? PH_RUN : PH_HOLD);
      PH_RUN: phase_d = hr_n_sync ? PH_RUN : PH_RESET;
      default: phase_d = PH_RESET;
    endcase
  end

  // pull-up stays on a few clocks past release so the sampled level settles
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= PH_RESET;
      hold_cnt_q <= 8'h0;
    end else begin
      phase_q <= phase_d;
      // reload outside the hold phase so every release gets the full window
      if (phase_q != PH_HOLD) begin
        hold_cnt_q <= HOLD_RELOAD;
      end else if (hold_cnt_q != 8'h0) begin
        hold_cnt_q <= hold_cnt_q - 8'h1;
      end
    end
  end

  // capture on release edge; values frozen until the next release edge
  // a later hard reset only drops valid; the old value stays visible meanwhile
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_value_q <= {CFG_W{1'b1}};
      ratio_value_q <= {RATIO_W{1'b0}};
      cfg_valid_q <= 1'b0;
    end else if (!hr_n_sync) begin
      cfg_valid_q <= 1'b0;
    end else if (capture_now) begin
      cfg_value_q <= cfg_s2_q;
      ratio_value_q <= ratio_s2_q;
      cfg_valid_q <= 1'b1;
    end
  end

  // receivers stay on through the hold window after capture, then drop
  // pull-ups follow the receivers exactly, so they never load a driving pad
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_rx_en_q <= {CFG_W{1'b1}};
      ratio_rx_en_q <= {RATIO_W{1'b1}};
      cfg_pullup_en_q <= {CFG_W{1'b1}};
    end else begin
      cfg_rx_en_q <= {CFG_W{listen_d}};
      ratio_rx_en_q <= {RATIO_W{listen_d}}; // no pull-up on these pads
      cfg_pullup_en_q <= {CFG_W{listen_d}};
    end
  end

  // config pads: drivers off while receivers listen, data forced low meanwhile
  assign cfg_pin_oe = ~cfg_rx_en_q;
  assign cfg_pin_o = func_out & ~cfg_rx_en_q;

  // ratio pads: same gating; no pull-up here, the board holds a firm level
  assign ratio_pin_oe = ~ratio_rx_en_q;
  assign ratio_pin_o = ratio_func_out & ~ratio_rx_en_q;

  // soft reset raises machine check as a level while held; hard reset masks it
  // a level keeps the core's view simple, but it clears only once the pin lets go
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      machine_check_q <= 1'b0;
    end else begin
      machine_check_q <= !sr_n_sync && hr_n_sync;
    end
  end

  // tap tracker: test reset or tms-high tck edges park it in reset
  rcs_tap_reset u_tap (
    .clk(clk),
    .nrst(nrst),
    .trst_n_sync(trst_n_sync),
    .tck_rise(tck_rise),
    .tms_sync(tms_sync),
    .tap_state_q(tap_state),
    .tap_in_reset(tap_in_reset)
  );
endmodule // rcs_strap_sampler

// ---- core/rcs_tap_reset.v ----
// tap state tracker that resets on test reset or on tms held high
// assumes tck and tms already synchronised to clk, tck_rise a one-cycle pulse
`include "rcs_regs.vh"
module rcs_tap_reset (
  input wire clk,
  input wire nrst,
  input wire trst_n_sync,
  input wire tck_rise,
  input wire tms_sync,
  output reg [3:0] tap_state_q,
  output wire tap_in_reset
);
  reg [3:0] tap_state_d;

  // standard 16-state walk; tms high from any state reaches reset in five steps
  always @* begin
    tap_state_d = tap_state_q;
    case (tap_state_q)
      `RCS_TAP_RESET: tap_state_d = tms_sync ? `RCS_TAP_RESET : `RCS_TAP_IDLE;
      `RCS_TAP_IDLE: tap_state_d = tms_sync ? `RCS_TAP_SEL_DR : `RCS_TAP_IDLE;
      `RCS_TAP_SEL_DR: tap_state_d = tms_sync ? `RCS_TAP_SEL_IR : `RCS_TAP_CAP_DR;
      `RCS_TAP_CAP_DR: tap_state_d = tms_sync ? `RCS_TAP_EXIT1_DR : `RCS_TAP_SHIFT_DR;
      `RCS_TAP_SHIFT_DR: tap_state_d = tms_sync ? `RCS_TAP_EXIT1_DR : `RCS_TAP_SHIFT_DR;
      `RCS_TAP_EXIT1_DR: tap_state_d = tms_sync ? `RCS_TAP_UPD_DR : `RCS_TAP_PAUSE_DR;
      `RCS_TAP_PAUSE_DR: tap_state_d = tms_sync ? `RCS_TAP_EXIT2_DR : `RCS_TAP_PAUSE_DR;
      `RCS_TAP_EXIT2_DR: tap_state_d = tms_sync ? `RCS_TAP_UPD_DR : `RCS_TAP_SHIFT_DR;
      `RCS_TAP_UPD_DR: tap_state_d = tms_sync ? `RCS_TAP_SEL_DR : `RCS_TAP_IDLE;
      `RCS_TAP_SEL_IR: tap_state_d = tms_sync ? `RCS_TAP_RESET : `RCS_TAP_CAP_IR;
      `RCS_TAP_CAP_IR: tap_state_d = tms_sync ? `RCS_TAP_EXIT1_IR : `RCS_TAP_SHIFT_IR;
      `RCS_TAP_SHIFT_IR: tap_state_d = tms_sync ? `RCS_TAP_EXIT1_IR : `RCS_TAP_SHIFT_IR;
      `RCS_TAP_EXIT1_IR: tap_state_d = tms_sync ? `RCS_TAP_UPD_IR : `RCS_TAP_PAUSE_IR;
      `RCS_TAP_PAUSE_IR: tap_state_d = tms_sync ? `RCS_TAP_EXIT2_IR : `RCS_TAP_PAUSE_IR;
      `RCS_TAP_EXIT2_IR: tap_state_d = tms_sync ? `RCS_TAP_UPD_IR : `RCS_TAP_SHIFT_IR;
      `RCS_TAP_UPD_IR: tap_state_d = tms_sync ? `RCS_TAP_SEL_DR : `RCS_TAP_IDLE;
      default: tap_state_d = `RCS_TAP_RESET;
    endcase
  end

  // test reset wins over any tck edge; acts as a synchronous clear here
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tap_state_q <= `RCS_TAP_RESET;
    end else if (!trst_n_sync) begin
      tap_state_q <= `RCS_TAP_RESET;
    end else if (tck_rise) begin
      tap_state_q <= tap_state_d;
    end
  end

  assign tap_in_reset = (tap_state_q == `RCS_TAP_RESET);
endmodule // rcs_tap_reset

// ---- dv/rcs_board.sv ----
// board side: strap resistors, pad levels, reset merge
// assumes a debug port is fitted unless DBG_USED is cleared
module rcs_board #(parameter bit DBG_USED = 1'b1) (
  input wire clk, sys_rst_n, dbg_hr_n, dbg_tr_n,
  input wire [15:0] pd_mask, cfg_pin_o, cfg_pin_oe, cfg_pullup_en_q,
  input wire [3:0] ratio_strap, ratio_pin_o, ratio_pin_oe,
  output logic [15:0] cfg_pin_i,
  output wire [3:0] ratio_pin_i,
  output wire hard_reset_n, trst_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] last_q;
  // debug port and system source merged; debug may assert either reset alone
  assign hard_reset_n = sys_rst_n & dbg_hr_n;
  // power-on reset always asserts test reset; tied to hard reset when no debug port
  assign trst_n = DBG_USED ? (sys_rst_n & dbg_tr_n) : hard_reset_n;
  // a released pad floats: show the inverse of its last level
  always @(negedge clk) last_q <= cfg_pin_i;
  always_comb for (int i = 0; i < 16; i++)
    cfg_pin_i[i] = cfg_pin_oe[i] ? cfg_pin_o[i] : pd_mask[i] ? 1'b0 : cfg_pullup_en_q[i] ? 1'b1 : ~last_q[i];
  // ratio pads have no pull-up, so the board holds a firm level
  assign ratio_pin_i = (ratio_pin_oe & ratio_pin_o) | (~ratio_pin_oe & ratio_strap);
endmodule // rcs_board

// ---- dv/rcs_strap_sampler_asserts.sv ----
// port checker for the strap sampler
// assumes one clock, nrst async low
module rcs_sva #(parameter CFG_W = 16, parameter RATIO_W = 4, parameter HOLD_CLKS = 4) (
  input wire clk, nrst, hard_reset_n, soft_reset_n, cfg_valid_q, machine_check_q, tap_in_reset,
  input wire [CFG_W-1:0] cfg_pin_i, cfg_pin_oe, cfg_pullup_en_q, cfg_rx_en_q, cfg_value_q,
  input wire [RATIO_W-1:0] ratio_pin_oe, ratio_rx_en_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // a pad never drives while its receiver listens
  oe_rx_a: assert property (cfg_pin_oe == ~cfg_rx_en_q && ratio_pin_oe == ~ratio_rx_en_q)
    else $error("oe");
  rx_listen_a: assert property (!hard_reset_n [*6] |-> &cfg_rx_en_q && &ratio_rx_en_q && !cfg_valid_q)
    else $error("listen");
  // capture follows release within a few clocks
  cap_time_a: assert property ($rose(hard_reset_n) |-> ##[2:5] cfg_valid_q)
    else $error("late");
  cap_val_a: assert property ($rose(cfg_valid_q) |-> cfg_value_q == $past(cfg_pin_i, 2))
    else $error("value");
  // pull-up outlives the capture, then leaves with the receiver
  rx_off_a: assert property ($rose(cfg_valid_q) |-> &cfg_rx_en_q ##[2:6] cfg_rx_en_q == 0)
    else $error("rx");
  pu_rx_a: assert property (cfg_pullup_en_q == cfg_rx_en_q)
    else $error("pullup");
  value_hold_a: assert property (cfg_valid_q && $past(cfg_valid_q) |-> $stable(cfg_value_q))
    else $error("moved");
  mc_raise_a: assert property ((!soft_reset_n && hard_reset_n) [*5] |-> machine_check_q)
    else $error("mc");
  mc_clear_a: assert property (soft_reset_n [*5] |-> !machine_check_q)
    else $error("mc stuck");
  cover property ($rose(cfg_valid_q));
  cover property ($rose(machine_check_q));
  cover property ($rose(tap_in_reset));
endmodule // rcs_sva
bind rcs_strap_sampler rcs_sva #(.CFG_W(CFG_W), .RATIO_W(RATIO_W), .HOLD_CLKS(HOLD_CLKS)) u_sva (
  .clk(clk), .nrst(nrst), .hard_reset_n(hard_reset_n), .soft_reset_n(soft_reset_n),
  .cfg_valid_q(cfg_valid_q), .machine_check_q(machine_check_q), .tap_in_reset(tap_in_reset),
  .cfg_pin_i(cfg_pin_i), .cfg_pin_oe(cfg_pin_oe), .cfg_pullup_en_q(cfg_pullup_en_q),
  .cfg_rx_en_q(cfg_rx_en_q), .cfg_value_q(cfg_value_q), .ratio_pin_oe(ratio_pin_oe),
  .ratio_rx_en_q(ratio_rx_en_q)
);

// ---- dv/tb.sv ----
// self-checking bench for the strap sampler
// assumes default widths and a hold count of four
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, nrst = 0, sys_rst_n = 0, dbg_hr_n = 1, dbg_tr_n = 1, soft_reset_n = 1, tck = 0, tms = 1;
  logic [15:0] pd_mask = 0, func_out = 0, cfg_pin_i, cfg_pin_o, cfg_pin_oe, cfg_pullup_en_q, cfg_rx_en_q;
  logic [15:0] cfg_value_q;
  logic [3:0] ratio_strap = 0, ratio_func_out = 0, ratio_pin_i, ratio_pin_o, ratio_pin_oe, ratio_rx_en_q;
  logic [3:0] ratio_value_q, tap_state;
  logic hard_reset_n, trst_n, cfg_valid_q, machine_check_q, tap_in_reset;
  int num_errors = 0, samples_checked = 0;
  rcs_strap_sampler DUT (
    .clk(clk), .nrst(nrst), .hard_reset_n(hard_reset_n), .soft_reset_n(soft_reset_n), .trst_n(trst_n),
    .tck(tck), .tms(tms), .cfg_pin_i(cfg_pin_i), .ratio_pin_i(ratio_pin_i), .func_out(func_out),
    .ratio_func_out(ratio_func_out), .cfg_pin_o(cfg_pin_o), .cfg_pin_oe(cfg_pin_oe), .ratio_pin_o(ratio_pin_o),
    .ratio_pin_oe(ratio_pin_oe), .cfg_pullup_en_q(cfg_pullup_en_q), .cfg_rx_en_q(cfg_rx_en_q),
    .ratio_rx_en_q(ratio_rx_en_q), .cfg_value_q(cfg_value_q), .ratio_value_q(ratio_value_q),
    .cfg_valid_q(cfg_valid_q), .machine_check_q(machine_check_q), .tap_state(tap_state),
    .tap_in_reset(tap_in_reset)
  );
  rcs_board brd (
    .clk(clk), .sys_rst_n(sys_rst_n), .dbg_hr_n(dbg_hr_n), .dbg_tr_n(dbg_tr_n), .pd_mask(pd_mask),
    .cfg_pin_o(cfg_pin_o), .cfg_pin_oe(cfg_pin_oe), .cfg_pullup_en_q(cfg_pullup_en_q), .ratio_strap(ratio_strap),
    .ratio_pin_o(ratio_pin_o), .ratio_pin_oe(ratio_pin_oe), .cfg_pin_i(cfg_pin_i), .ratio_pin_i(ratio_pin_i),
    .hard_reset_n(hard_reset_n), .trst_n(trst_n)
  );
  initial forever #50 clk = ~clk;
  // shared compare and pacing
  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic final_report;
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hold reset, release, then the pads return to output duty
  task automatic t_cap(input logic [15:0] m, input logic [3:0] r, input bit dbg);
    pd_mask = m;
    ratio_strap = r;
    sys_rst_n = dbg;
    dbg_hr_n = !dbg;
    cyc(8);
    chk(cfg_rx_en_q === 16'hffff && cfg_pin_oe === 16'h0 && cfg_valid_q === 1'b0, "listen");
    sys_rst_n = 1;
    dbg_hr_n = 1;
    cyc(4);
    chk(cfg_value_q === ~m && ratio_value_q === r && cfg_pullup_en_q === 16'hffff, "capture");
    cyc(4);
    chk(cfg_pullup_en_q === 16'h0 && cfg_pin_oe === 16'hffff && ratio_pin_oe === 4'hf, "release");
    func_out = m;
    ratio_func_out = ~r;
    cyc(2);
    chk(cfg_pin_o === m && cfg_value_q === ~m, "output duty");
    chk(ratio_pin_o === ~r && ratio_value_q === r, "ratio duty");
  endtask
  // soft reset: machine check only while held
  task automatic t_mc;
    soft_reset_n = 0;
    cyc(5);
    chk(machine_check_q === 1'b1, "mc on");
    soft_reset_n = 1;
    cyc(5);
    chk(machine_check_q === 1'b0, "mc off");
  endtask
  // slow tck pulse, four clocks, to stay inside the sampling limit
  task automatic tck_pulse(input logic s);
    tms = s;
    cyc(2);
    tck = 1;
    cyc(2);
    tck = 0;
  endtask
  // leave test-logic-reset, return by tms alone, then by test reset
  task automatic t_tap;
    tck_pulse(0);
    cyc(3);
    chk(tap_in_reset === 1'b0, "tap idle");
    repeat (5) tck_pulse(1);
    cyc(3);
    chk(tap_in_reset === 1'b1 && tap_state === 4'h0, "tms reset");
    tck_pulse(0);
    cyc(3);
    chk(tap_in_reset === 1'b0, "tap left reset");
    dbg_tr_n = 0;
    cyc(4);
    chk(tap_in_reset === 1'b1 && hard_reset_n === 1'b1, "trst reset");
    dbg_tr_n = 1;
  endtask
  initial begin
    cyc(2);
    nrst = 1;
    t_cap(16'h0000, 4'h5, 0);
    t_cap(16'ha5c3, 4'ha, 0);
    t_cap(16'hffff, 4'h0, 1);
    t_mc;
    t_tap;
    final_report;
  end
  // watchdog: the run needs far fewer than 3000 clocks
  initial begin
    #300000;
    num_errors++;
    final_report;
  end
endmodule // tb
